// ===== core/cpdm_cfg.svh
/*
  Constants of the process-data mapper: register offsets, reset values,
  field positions and identifier type codes.
  Assumes inclusion by bare name from the mapper's design and verification files.
*/
`ifndef CPDM_CFG_SVH
`define CPDM_CFG_SVH

// Register byte offsets, one aligned word each
`define CPDM_OFS_CTRL 8'h00
`define CPDM_OFS_NODE 8'h04
`define CPDM_OFS_TXID 8'h08
`define CPDM_OFS_RXID 8'h0C
`define CPDM_OFS_DROP 8'h10
// Windows of eight words (tx map, rx map) and four words (slots)
`define CPDM_WIN_TXMAP 3'h1
`define CPDM_WIN_RXMAP 3'h2
`define CPDM_WIN_SLOT 3'h3
`define CPDM_SUB_TXVAL 1'h0
`define CPDM_SUB_RXVAL 1'h1
`define CPDM_WIN_LIMIT 4'h8

// Control register bit positions
`define CPDM_CTRL_OPKEY 0
`define CPDM_CTRL_GOOP 1
`define CPDM_CTRL_GOPRE 2
`define CPDM_STAT_OPER 8
`define CPDM_STAT_KEY 9

// Mapping entry fields: length, sub-index, object index
`define CPDM_MAP_LEN_HI 31
`define CPDM_MAP_LEN_LO 24
`define CPDM_MAP_SUB_HI 23
`define CPDM_MAP_SUB_LO 16
`define CPDM_MAP_OBJ_HI 15
`define CPDM_MAP_OBJ_LO 0
`define CPDM_MAP_DEF 32'h0800_3330
`define CPDM_MAP_SUB_STEP 32'h0001_0000
`define CPDM_OBJ_BASE 16'h3330
`define CPDM_OBJ_LAST 16'h3333
`define CPDM_SUB_HIGH 8'h00
`define CPDM_SUB_LOW 8'h01

// Node number and identifier construction
`define CPDM_NODE_DEF 7'h26
`define CPDM_NODE_MIN 7'h01
`define CPDM_TX_TYPE 4'h3
`define CPDM_RX_TYPE 4'h2

// Scaled full range, in tenths of a percent
`define CPDM_FULL_SCALE 16'h03E8

`endif

// ===== core/cpdm_pkg.sv
/*
  Types of the process-data mapper: frame carrier, mapping decode result
  and network state.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cpdm_pkg;

  // One process-data message; data byte n (1..8) sits at bits [8n-1:8n-8]
  typedef struct packed {
    logic [10:0] id;
    logic [3:0] len;
    logic [63:0] data;
  } cpdm_frame_type;

  // Decoded mapping entry
  typedef struct packed {
    logic hit;
    logic [1:0] slot;
    logic low;
  } cpdm_map_type;

  typedef enum logic [0:0] {
    CPDM_PREOP,
    CPDM_OPER
  } cpdm_state_type;

endpackage

// ===== core/cpdm_scale.sv
/*
  One host value slot scaler: passes a raw value or scales it linearly
  between min and max into the normalized range, registered on load.
  Assumes load is a single-cycle pulse from the mapper on the same clock.
*/
`timescale 1ns/100ps
`include "cpdm_cfg.svh"

module cpdm_scale
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic [15:0] i_raw,
  input wire logic [15:0] i_min,
  input wire logic [15:0] i_max,
  output logic [15:0] o_value
);

  logic signed [16:0] num;
  logic signed [16:0] span;
  logic [31:0] prod;
  logic [31:0] quot;
  logic [15:0] value_d;

  // Signed span so a bidirectional range such as -4095..4095 maps cleanly
  always_comb
  begin
    num = {i_raw[15], i_raw} - {i_min[15], i_min};
    span = {i_max[15], i_max} - {i_min[15], i_min};
    prod = {16'h0000, num[15:0]} * {16'h0000, `CPDM_FULL_SCALE};
    quot = 32'h0000_0000;
    if ((i_min == 16'h0000) && (i_max == 16'h0000))
      value_d = i_raw;
    else if (num[16] || (num == 17'h0_0000) || span[16] || (span == 17'h0_0000))
      value_d = 16'h0000; // Below min, or a span that cannot scale
    else if (num >= span)
      value_d = `CPDM_FULL_SCALE;
    else
    begin
      quot = prod / {16'h0000, span[15:0]};
      value_d = quot[15:0];
    end
  end

  // Result held until the next accepted message touches this slot
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_value <= 16'h0000;
    else if (i_ce && i_load)
      o_value <= value_d;
  end

endmodule

// ===== core/cpdm_top.sv
/*
  Process-data mapper: maps the eight data bytes of the first received and
  transmitted process-data messages onto four 16-bit host value slots,
  builds the message identifiers from the node number and follows the
  key switch into the operational state.
  Assumes a CAN controller on the same clock that presents received frames
  as one-cycle pulses and asks for a transmit frame with a one-cycle pulse,
  and a register master that never waits.
*/
`timescale 1ns/100ps
`include "cpdm_cfg.svh"

// What this block does
// - Every mapping entry is read as length in the top byte, sub-index next, object index in the low 16 bits.
// - Transmit byte 1 entry resets to length 8, sub-index 0, first slot object.
// - Transmit bytes 1 to 8 default to slots 1 to 4, two bytes per slot via sub-indices 0 and 1.
// - Receive bytes 1 to 8 default to the same slot layout as transmit.
// - Node number resets to 38 and writing a nonzero value recomputes both message identifiers.
// - With node 38 the first receive message is accepted on identifier 294.
// - A slot with min and max both zero passes its value raw, otherwise scales it into 0-100%.
// - Slot two carries a signed throttle from -4095 to 4095 that is scaled into the normalized range.
// - With operational-on-key enabled the block goes operational as soon as the key switch becomes active.
// - Sub-index 0 carries slot bits 15 to 8 and sub-index 1 carries bits 7 to 0.
// - The transmit identifier is type 0011 then the 7-bit node number, which stays within 1 to 127.
module cpdm_top
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_key_switch_input,
  input wire logic i_rx_valid,
  input wire cpdm_pkg::cpdm_frame_type i_rx_frame,
  input wire logic i_tx_req,
  output logic o_tx_valid,
  output cpdm_pkg::cpdm_frame_type o_tx_frame,
  output logic o_operational,
  output logic [3:0][15:0] o_rx_slot
);

  cpdm_pkg::cpdm_state_type state_q;
  logic op_on_key_q;
  logic [6:0] network_node_number_q;
  logic [10:0] tx_id_q;
  logic [10:0] rx_id_q;
  logic [15:0] drop_q;
  logic [31:0] tx_map_q [8];
  logic [31:0] rx_map_q [8];
  logic [15:0] tx_slot_q [4];
  logic [15:0] raw_q [4];
  logic [15:0] raw_d [4];
  logic [15:0] min_q [4];
  logic [15:0] max_q [4];
  logic [3:0] touch;
  logic [63:0] tx_data_d;
  logic ks_s1_q;
  logic ks_s2_q;
  logic ks_s3_q;
  logic ks_q;
  logic ks_rise;
  logic id_ok;
  logic len_ok;
  logic accept;
  logic reject;
  logic wr_ctrl;
  logic wr_node;

  // Decode one mapping entry onto a slot and a byte half
  function automatic cpdm_pkg::cpdm_map_type map_decode(input logic [31:0] e);
    cpdm_pkg::cpdm_map_type m;
    logic [15:0] obj;
    logic [7:0] sub;
    logic [15:0] rel;
    obj = e[`CPDM_MAP_OBJ_HI:`CPDM_MAP_OBJ_LO];
    sub = e[`CPDM_MAP_SUB_HI:`CPDM_MAP_SUB_LO];
    rel = obj - `CPDM_OBJ_BASE;
    m.hit = (obj >= `CPDM_OBJ_BASE) && (obj <= `CPDM_OBJ_LAST) &&
            ((sub == `CPDM_SUB_HIGH) || (sub == `CPDM_SUB_LOW));
    m.slot = rel[1:0];
    m.low = (sub == `CPDM_SUB_LOW);
    return m;
  endfunction

  // Key switch pin: three stages, a change counts once stages two and three agree
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ks_s1_q <= 1'b0;
      ks_s2_q <= 1'b0;
      ks_s3_q <= 1'b0;
      ks_q <= 1'b0;
    end
    else if (i_ce)
    begin
      ks_s1_q <= i_key_switch_input;
      ks_s2_q <= ks_s1_q;
      ks_s3_q <= ks_s2_q;
      if (ks_s2_q == ks_s3_q)
        ks_q <= ks_s3_q;
    end
  end

  assign ks_rise = (ks_s2_q == ks_s3_q) && ks_s3_q && !ks_q;
  assign wr_ctrl = i_wr && (i_addr == `CPDM_OFS_CTRL);
  assign wr_node = i_wr && (i_addr == `CPDM_OFS_NODE);

  // Network state; a software command in the same cycle as the key edge wins
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      state_q <= cpdm_pkg::CPDM_PREOP;
    else if (i_ce)
    begin
      case (state_q)
        cpdm_pkg::CPDM_PREOP:
          if (wr_ctrl && i_wdata[`CPDM_CTRL_GOOP])
            state_q <= cpdm_pkg::CPDM_OPER;
          else if (op_on_key_q && (ks_rise || ks_q))
            state_q <= cpdm_pkg::CPDM_OPER;
        cpdm_pkg::CPDM_OPER:
          if (wr_ctrl && i_wdata[`CPDM_CTRL_GOPRE])
            state_q <= cpdm_pkg::CPDM_PREOP;
        default:
          state_q <= cpdm_pkg::CPDM_PREOP;
      endcase
    end
  end

  // Control and node number; identifiers follow every accepted node write
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      op_on_key_q <= 1'b0;
      network_node_number_q <= `CPDM_NODE_DEF;
      tx_id_q <= {`CPDM_TX_TYPE, `CPDM_NODE_DEF};
      rx_id_q <= {`CPDM_RX_TYPE, `CPDM_NODE_DEF};
    end
    else if (i_ce)
    begin
      if (wr_ctrl)
        op_on_key_q <= i_wdata[`CPDM_CTRL_OPKEY];
      // Node 0 is not a legal node, so such a write is ignored
      if (wr_node && (i_wdata[6:0] >= `CPDM_NODE_MIN))
      begin
        network_node_number_q <= i_wdata[6:0];
        tx_id_q <= {`CPDM_TX_TYPE, i_wdata[6:0]};
        rx_id_q <= {`CPDM_RX_TYPE, i_wdata[6:0]};
      end
      else if (i_wr && (i_addr == `CPDM_OFS_RXID))
        rx_id_q <= i_wdata[10:0];
    end
  end

  // Mapping tables, transmit slot values and slot limits
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      for (int k = 0; k < 8; k++)
      begin
        tx_map_q[k] <= `CPDM_MAP_DEF + 32'(k / 2) + ((k % 2 == 1) ? `CPDM_MAP_SUB_STEP : 32'h0000_0000);
        rx_map_q[k] <= `CPDM_MAP_DEF + 32'(k / 2) + ((k % 2 == 1) ? `CPDM_MAP_SUB_STEP : 32'h0000_0000);
      end
      for (int s = 0; s < 4; s++)
      begin
        tx_slot_q[s] <= 16'h0000;
        min_q[s] <= 16'h0000;
        max_q[s] <= 16'h0000;
      end
    end
    else if (i_ce && i_wr)
    begin
      if (i_addr[7:5] == `CPDM_WIN_TXMAP)
        tx_map_q[i_addr[4:2]] <= i_wdata;
      else if (i_addr[7:5] == `CPDM_WIN_RXMAP)
        rx_map_q[i_addr[4:2]] <= i_wdata;
      else if ((i_addr[7:5] == `CPDM_WIN_SLOT) && (i_addr[4] == `CPDM_SUB_TXVAL))
        tx_slot_q[i_addr[3:2]] <= i_wdata[15:0];
      else if (i_addr[7:4] == `CPDM_WIN_LIMIT)
      begin
        min_q[i_addr[3:2]] <= i_wdata[15:0];
        max_q[i_addr[3:2]] <= i_wdata[31:16];
      end
    end
  end

  // Receive acceptance: identifier and mapped length must both match
  assign id_ok = (i_rx_frame.id == rx_id_q);
  assign len_ok = ({4'h0, i_rx_frame.len} == rx_map_q[0][`CPDM_MAP_LEN_HI:`CPDM_MAP_LEN_LO]);
  assign accept = i_rx_valid && (state_q == cpdm_pkg::CPDM_OPER) && id_ok && len_ok;
  assign reject = i_rx_valid && (state_q == cpdm_pkg::CPDM_OPER) && id_ok && !len_ok;

  // Gather received bytes into slot raw values; unmapped halves keep old data
  always_comb
  begin
    cpdm_pkg::cpdm_map_type m;
    m = '0;
    touch = 4'h0;
    for (int s = 0; s < 4; s++)
      raw_d[s] = raw_q[s];
    for (int k = 0; k < 8; k++)
    begin
      m = map_decode(rx_map_q[k]);
      if (m.hit)
      begin
        touch[m.slot] = 1'b1;
        if (m.low)
          raw_d[m.slot][7:0] = i_rx_frame.data[8*k +: 8];
        else
          raw_d[m.slot][15:8] = i_rx_frame.data[8*k +: 8];
      end
    end
  end

  // Raw slot store, written only by an accepted message
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      for (int s = 0; s < 4; s++)
        raw_q[s] <= 16'h0000;
    end
    else if (i_ce && accept)
    begin
      for (int s = 0; s < 4; s++)
        raw_q[s] <= raw_d[s];
    end
  end

  // Count messages on our identifier refused for their length
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      drop_q <= 16'h0000;
    else if (i_ce && reject && (drop_q != 16'hFFFF))
      drop_q <= drop_q + 16'h0001;
  end

  // One scaler per slot, each loaded only when its slot was touched
  for (genvar s = 0; s < 4; s++)
  begin : g_slot
    cpdm_scale u_scale
    (
      .i_mclk(i_mclk),
      .i_arst_n(i_arst_n),
      .i_ce(i_ce),
      .i_load(accept && touch[s]),
      .i_raw(raw_d[s]),
      .i_min(min_q[s]),
      .i_max(max_q[s]),
      .o_value(o_rx_slot[s])
    );
  end

  // Spread transmit slots over the eight data bytes
  always_comb
  begin
    cpdm_pkg::cpdm_map_type m;
    m = '0;
    tx_data_d = 64'h0000_0000_0000_0000;
    for (int k = 0; k < 8; k++)
    begin
      m = map_decode(tx_map_q[k]);
      if (m.hit)
        tx_data_d[8*k +: 8] = m.low ? tx_slot_q[m.slot][7:0] : tx_slot_q[m.slot][15:8];
    end
  end

  // Transmit frame, built on request while operational
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_tx_valid <= 1'b0;
      o_tx_frame <= '0;
    end
    else if (i_ce)
    begin
      o_tx_valid <= i_tx_req && (state_q == cpdm_pkg::CPDM_OPER);
      if (i_tx_req && (state_q == cpdm_pkg::CPDM_OPER))
      begin
        o_tx_frame.id <= tx_id_q;
        o_tx_frame.len <= tx_map_q[0][`CPDM_MAP_LEN_LO +: 4];
        o_tx_frame.data <= tx_data_d;
      end
    end
  end

  // Operational flag mirrored onto a port
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_operational <= 1'b0;
    else if (i_ce)
      o_operational <= (state_q == cpdm_pkg::CPDM_OPER);
  end

  // Read data in the cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_rdata <= 32'h0000_0000;
    else if (i_ce)
    begin
      o_rdata <= 32'h0000_0000;
      if (i_rd)
      begin
        if (i_addr == `CPDM_OFS_CTRL)
        begin
          o_rdata[`CPDM_CTRL_OPKEY] <= op_on_key_q;
          o_rdata[`CPDM_STAT_OPER] <= (state_q == cpdm_pkg::CPDM_OPER);
          o_rdata[`CPDM_STAT_KEY] <= ks_q;
        end
        else if (i_addr == `CPDM_OFS_NODE)
          o_rdata[6:0] <= network_node_number_q;
        else if (i_addr == `CPDM_OFS_TXID)
          o_rdata[10:0] <= tx_id_q;
        else if (i_addr == `CPDM_OFS_RXID)
          o_rdata[10:0] <= rx_id_q;
        else if (i_addr == `CPDM_OFS_DROP)
          o_rdata[15:0] <= drop_q;
        else if (i_addr[7:5] == `CPDM_WIN_TXMAP)
          o_rdata <= tx_map_q[i_addr[4:2]];
        else if (i_addr[7:5] == `CPDM_WIN_RXMAP)
          o_rdata <= rx_map_q[i_addr[4:2]];
        else if ((i_addr[7:5] == `CPDM_WIN_SLOT) && (i_addr[4] == `CPDM_SUB_TXVAL))
          o_rdata[15:0] <= tx_slot_q[i_addr[3:2]];
        else if ((i_addr[7:5] == `CPDM_WIN_SLOT) && (i_addr[4] == `CPDM_SUB_RXVAL))
          o_rdata[15:0] <= o_rx_slot[i_addr[3:2]];
        else if (i_addr[7:4] == `CPDM_WIN_LIMIT)
          o_rdata <= {max_q[i_addr[3:2]], min_q[i_addr[3:2]]};
      end
    end
  end

endmodule

// ===== verification/cpdm_top_sva.sv
/*
  Port-level checks of the process-data mapper, bound into the top module.
  Assumes one clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
`include "cpdm_cfg.svh"
module cpdm_top_chk
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_rx_valid,
  input wire logic i_tx_req,
  input wire logic o_tx_valid,
  input wire cpdm_pkg::cpdm_frame_type o_tx_frame,
  input wire logic o_operational,
  input wire logic [3:0][15:0] o_rx_slot
);
  // Causes, judged one or two edges before their effects; the operational
  // flag lags the state by one edge, so it is read one edge after the cause
  wire logic rx_take = i_ce && i_rx_valid;
  wire logic pre_cmd = i_ce && i_wr && i_addr == `CPDM_OFS_CTRL && i_wdata[`CPDM_CTRL_GOPRE];

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);

  a_tx_answer: assert property (i_ce && i_tx_req |=> o_tx_valid == o_operational)
    else $error("transmit request answered against state");
  a_tx_refuse: assert property (i_ce && !i_tx_req |=> !o_tx_valid)
    else $error("transmit pulse without request");
  a_tx_hold: assert property ($changed(o_tx_frame) |-> o_tx_valid)
    else $error("transmit frame moved without pulse");
  a_tx_ident: assert property (o_tx_valid |-> o_tx_frame.id[10:7] == 4'h3 && o_tx_frame.id[6:0] != 7'h00)
    else $error("transmit identifier malformed");
  // The scaler loads on the accepting edge, so a slot moves one edge after its frame
  a_slot_cause: assert property ($changed(o_rx_slot) |-> $past(rx_take) && o_operational)
    else $error("slot changed without accepted frame");
  a_ce_freeze: assert property (!i_ce |=> $stable(o_operational) && $stable(o_rx_slot) && $stable(o_tx_frame))
    else $error("state moved with clock enable low");
  a_op_leave: assert property ($fell(o_operational) |-> $past(pre_cmd, 2))
    else $error("left operational without command");
  a_txid_read: assert property (i_ce && i_rd && i_addr == `CPDM_OFS_TXID |=> o_rdata[31:7] == 25'h000_0003)
    else $error("transmit identifier read malformed");

  c_tx: cover property (o_tx_valid);
  c_rx: cover property ($changed(o_rx_slot));
  c_leave: cover property ($fell(o_operational));
endmodule

bind cpdm_top cpdm_top_chk u_chk
(
  .i_mclk(i_mclk),
  .i_arst_n(i_arst_n),
  .i_ce(i_ce),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .i_rx_valid(i_rx_valid),
  .i_tx_req(i_tx_req),
  .o_tx_valid(o_tx_valid),
  .o_tx_frame(o_tx_frame),
  .o_operational(o_operational),
  .o_rx_slot(o_rx_slot)
);

// ===== verification/cpdm_mgr.sv
/*
  Manager controller model: sends process-data frames, polls transmit.
  Assumes the mapper's clock; each call may wait some idle cycles first.
*/
`timescale 1ns/100ps
module cpdm_mgr
(
  input wire logic i_mclk,
  output logic o_rx_valid,
  output cpdm_pkg::cpdm_frame_type o_rx_frame,
  output logic o_tx_req
);
  // Idle bus at time zero
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_frame = '0;
    o_tx_req = 1'b0;
  end

  // Frame in the mapper's layout; lines scramble once released
  task automatic send(input cpdm_pkg::cpdm_frame_type f, input int gap);
    repeat (gap + 1) @(posedge i_mclk);
    o_rx_valid <= 1'b1;
    o_rx_frame <= f;
    @(posedge i_mclk);
    o_rx_valid <= 1'b0;
    o_rx_frame <= ~f;
  endtask

  // Transmit poll, a one-cycle request
  task automatic poll(input int gap);
    repeat (gap + 1) @(posedge i_mclk);
    o_tx_req <= 1'b1;
    @(posedge i_mclk);
    o_tx_req <= 1'b0;
  endtask
endmodule

// ===== verification/cpdm_top_test.sv
/*
  Self-checking bench of the process-data mapper with seeded random data.
  Assumes the manager model and the bound checker are compiled first.
*/
`timescale 1ns/100ps
`include "cpdm_cfg.svh"
module cpdm_top_test;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic key = 1'b0;
  logic rx_valid, tx_req, tx_valid, oper;
  logic [31:0] rdata, d;
  cpdm_pkg::cpdm_frame_type rx_frame, tx_frame;
  cpdm_pkg::cpdm_frame_type last = '0;
  logic [3:0][15:0] slot, v, x, t;
  logic [63:0] e;
  logic [10:0] tid = 11'h1A6;
  logic [6:0] n;
  logic [15:0] raws [3] = '{16'hF001, 16'h0000, 16'h0FFF};
  int miscompares = 0;
  int check_count = 0;

  // 25 ns clock
  always #12.5 clk = ~clk;

  cpdm_top dut
  (
    .i_mclk(clk),
    .i_arst_n(arst_n),
    .i_ce(ce),
    .i_addr(addr),
    .i_wdata(wdata),
    .i_wr(wr),
    .i_rd(rd),
    .o_rdata(rdata),
    .i_key_switch_input(key),
    .i_rx_valid(rx_valid),
    .i_rx_frame(rx_frame),
    .i_tx_req(tx_req),
    .o_tx_valid(tx_valid),
    .o_tx_frame(tx_frame),
    .o_operational(oper),
    .o_rx_slot(slot)
  );

  cpdm_mgr mgr
  (
    .i_mclk(clk),
    .o_rx_valid(rx_valid),
    .o_rx_frame(rx_frame),
    .o_tx_req(tx_req)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobes start on an edge, so two calls never touch a strobe in one step
  task automatic wreg(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk);
    addr <= a;
    wdata <= w;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] r);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    r = rdata;
  endtask

  // Slot value s goes out high byte first
  function automatic logic [63:0] pk(input logic [3:0][15:0] s);
    logic [63:0] r;
    for (int i = 0; i < 4; i++)
      r[16*i +: 16] = {s[i][7:0], s[i][15:8]};
    return r;
  endfunction

  function automatic logic [15:0] scl(input logic [15:0] r, input logic [15:0] lo, input logic [15:0] hi);
    int a;
    int b;
    a = int'($signed(r)) - int'($signed(lo));
    b = int'($signed(hi)) - int'($signed(lo));
    if (lo == 16'h0000 && hi == 16'h0000)
      return r;
    if (b <= 0 || a <= 0)
      return 16'h0000;
    if (a >= b)
      return 16'h03E8;
    return 16'(a * 1000 / b);
  endfunction

  task automatic sl(input logic [3:0][15:0] q);
    repeat (2) @(posedge clk);
    #1;
    for (int i = 0; i < 4; i++)
      chk({16'h0000, slot[i]}, {16'h0000, q[i]});
  endtask

  // A refused request leaves the last built frame in place
  task automatic txc(input logic [63:0] q, input logic [31:0] ok);
    mgr.poll($urandom_range(3, 0));
    #1;
    chk({31'h0000_0000, tx_valid}, ok);
    if (ok[0])
      last = {tid, 4'h8, q};
    chk({17'h0_0000, tx_frame.id, tx_frame.len}, {17'h0_0000, last.id, last.len});
    chk(tx_frame.data[31:0], last.data[31:0]);
    chk(tx_frame.data[63:32], last.data[63:32]);
  endtask

  task automatic test_done();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // A full run takes about 200 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end

  initial
  begin
    void'($urandom(32'hefd0f8be));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rreg(`CPDM_OFS_NODE, d);
    chk(d, 32'h0000_0026);
    rreg(`CPDM_OFS_TXID, d);
    chk(d, 32'h0000_01A6);
    rreg(`CPDM_OFS_RXID, d);
    chk(d, 32'h0000_0126);
    rreg(8'hFC, d);
    chk(d, 32'h0000_0000);
    for (int k = 0; k < 8; k++)
    begin
      e[31:0] = 32'h0800_3330 + 32'(k / 2) + ((k % 2) ? 32'h0001_0000 : 32'h0000_0000);
      rreg(8'(8'h20 + 4 * k), d);
      chk(d, e[31:0]);
      rreg(8'(8'h40 + 4 * k), d);
      chk(d, e[31:0]);
    end
    // Preop refuses transmit; the key brings the block up
    txc(64'h0, 32'h0000_0000);
    wreg(`CPDM_OFS_CTRL, 32'h0000_0001);
    key <= 1'b1;
    for (int i = 0; i < 12 && oper !== 1'b1; i++)
      @(posedge clk);
    #1;
    chk({31'h0000_0000, oper}, 32'h0000_0001);
    rreg(`CPDM_OFS_CTRL, d);
    chk(d, 32'h0000_0301);
    repeat (4)
    begin
      v = {$urandom, $urandom};
      mgr.send({11'h126, 4'h8, pk(v)}, $urandom_range(3, 0));
      sl(v);
    end
    // Wrong length then wrong identifier leave every slot alone
    mgr.send({11'h126, 4'h7, pk(~v)}, 0);
    sl(v);
    rreg(`CPDM_OFS_DROP, d);
    chk(d, 32'h0000_0001);
    mgr.send({11'h127, 4'h8, pk(~v)}, 0);
    sl(v);
    t = {$urandom, $urandom};
    for (int s = 0; s < 4; s++)
      wreg(8'(8'h60 + 4 * s), {16'h0000, t[s]});
    txc(pk(t), 32'h0000_0001);
    // Byte 1 remapped onto the low half of slot two
    wreg(8'h20, 32'h0801_3331);
    e = pk(t);
    e[7:0] = t[1][7:0];
    txc(e, 32'h0000_0001);
    wreg(8'h20, `CPDM_MAP_DEF);
    wreg(8'h84, 32'h0FFF_F001);
    for (int i = 0; i < 6; i++)
    begin
      v[1] = (i < 3) ? raws[i] : 16'($urandom);
      x = v;
      x[1] = scl(v[1], 16'hF001, 16'h0FFF);
      mgr.send({11'h126, 4'h8, pk(v)}, 0);
      sl(x);
    end
    rreg(8'h74, d);
    chk(d, {16'h0000, x[1]});
    // Frozen clock enable swallows a request
    @(posedge clk);
    ce <= 1'b0;
    txc(pk(t), 32'h0000_0000);
    @(posedge clk);
    ce <= 1'b1;
    wreg(`CPDM_OFS_NODE, 32'h0000_0000);
    rreg(`CPDM_OFS_NODE, d);
    chk(d, 32'h0000_0026);
    for (int i = 0; i < 5; i++)
    begin
      n = (i == 0) ? 7'h01 : (i == 1) ? 7'h7F : 7'($urandom_range(127, 1));
      wreg(`CPDM_OFS_NODE, {25'h000_0000, n});
      rreg(`CPDM_OFS_TXID, d);
      chk(d, {21'h00_0000, 4'h3, n});
      rreg(`CPDM_OFS_RXID, d);
      chk(d, {21'h00_0000, 4'h2, n});
    end
    tid = {4'h3, n};
    txc(pk(t), 32'h0000_0001);
    // Leaving operational, later frames are ignored
    wreg(`CPDM_OFS_CTRL, 32'h0000_0004);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0000_0000, oper}, 32'h0000_0000);
    mgr.send({4'h2, n, 4'h8, pk(~v)}, 0);
    sl(x);
    // Software command brings the block back up without the key
    wreg(`CPDM_OFS_CTRL, 32'h0000_0002);
    rreg(`CPDM_OFS_CTRL, d);
    chk(d, 32'h0000_0300);
    test_done();
  end
endmodule
